// [lcdb_pkg.sv]
// ****************************************************************
// Shared constants and types of the segment display driver.
// ****************************************************************
package lcdb_pkg;

  // ****************************************************************
  // Clock rates and the sub-clock divider.
  // ****************************************************************
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned SUB_CLK_HZ = 32_768;
  // A whole number of system cycles per sub-clock tick, rounded down.
  localparam int unsigned SUB_DIV    = SYS_CLK_HZ / SUB_CLK_HZ;
  localparam int unsigned DIV_W      = 12;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SUB_DIV - 1);

  // ****************************************************************
  // Geometry: four common lines, eight segment lines.
  // ****************************************************************
  localparam int unsigned NUM_COM = 4;
  localparam int unsigned NUM_SEG = 8;
  localparam int unsigned SLOT_W  = 2;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 2'h3;

  // ****************************************************************
  // Register bus: word addresses.
  // ****************************************************************
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h1;
  // Display memory occupies addresses 8 to 15, one word per segment.
  localparam logic [ADDR_W-1:0] ADDR_MEM_BASE = 4'h8;
  localparam int unsigned       MEM_SEL_BIT   = 3;

  // ****************************************************************
  // Control register layout (display_control_reg_zero).
  // ****************************************************************
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_WAVE_BIT  = 1;
  localparam int unsigned CTRL_SRC_LSB   = 2;
  localparam int unsigned CTRL_BIAS_BIT  = 4;

  // Source choices for C type bias.
  typedef enum logic [1:0] {
    SRC_SUPPLY_PIN = 2'h0,
    SRC_FIRST_PIN  = 2'h1,
    SRC_SECOND_PIN = 2'h2,
    SRC_INTERNAL   = 2'h3
  } lcdb_src_type;

  typedef struct packed {
    logic         bias_style_select;   // 1 selects C type biasing.
    lcdb_src_type cbias_source_select;
    logic         wave_type_b;         // 1 selects the slower style.
    logic         display_drive_enable;
  } lcdb_ctrl_type;

  localparam lcdb_ctrl_type CTRL_RESET = '{1'b0, SRC_SUPPLY_PIN, 1'b0, 1'b0};

  // ****************************************************************
  // Drive level codes on the 1/3 bias ladder.
  // ****************************************************************
  typedef enum logic [1:0] {
    LVL_VSS = 2'h0,
    LVL_VC  = 2'h1,
    LVL_VB  = 2'h2,
    LVL_VA  = 2'h3
  } lcdb_level_type;

  // Output mode of the pads.
  typedef enum logic [1:0] {
    MODE_FLOAT,
    MODE_LOW,
    MODE_RUN
  } lcdb_mode_type;

endpackage : lcdb_pkg

// [lcdb_driver.sv]
`timescale 1ns/1ps
module lcdb_driver
  import lcdb_pkg::*;
(
  input  wire logic                                clk_sys,
  input  wire logic                                rst,
  input  wire logic [lcdb_pkg::ADDR_W-1:0]         reg_addr,
  input  wire logic [lcdb_pkg::DATA_W-1:0]         reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [lcdb_pkg::DATA_W-1:0]         reg_rdata,
  input  wire logic                                sleep_mode,
  input  wire logic                                idle_mode,
  input  wire logic                                mcu_reset,
  input  wire logic                                wdt_reset,
  output lcdb_pkg::lcdb_level_type [lcdb_pkg::NUM_COM-1:0] com_level,
  output logic      [lcdb_pkg::NUM_COM-1:0]        com_oe,
  output lcdb_pkg::lcdb_level_type [lcdb_pkg::NUM_SEG-1:0] segment_output,
  output logic      [lcdb_pkg::NUM_SEG-1:0]        segment_oe,
  output logic                                     cbias_select,
  output lcdb_pkg::lcdb_src_type                   cbias_source,
  output logic                                     cpump_enable,
  output logic                                     cpump_boost
);
  import lcdb_pkg::*;

  // ****************************************************************
  // Reset qualification.
  // ****************************************************************
  logic          mcu_reset_eff;
  logic          drv_reset;
  lcdb_mode_type mode_d;

  // A watchdog time-out while idle or asleep only wakes the core, so
  // it must not float the glass.
  assign mcu_reset_eff = mcu_reset
                       & ~(wdt_reset & (idle_mode | sleep_mode));

  lcdb_ctrl_type ctrl_q;

  // Internal driver reset: enable cleared or the chip asleep.
  assign drv_reset = ~ctrl_q.display_drive_enable | sleep_mode;

  // Pick the pad mode; MCU reset has the highest priority.
  always_comb
  begin
    if (mcu_reset_eff)
    begin
      mode_d = MODE_FLOAT;
    end
    else if (drv_reset)
    begin
      mode_d = MODE_LOW;
    end
    else
    begin
      mode_d = MODE_RUN;
    end
  end

  // ****************************************************************
  // Register bus.
  // ****************************************************************
  logic wr_ctrl;
  logic wr_mem;

  assign wr_ctrl = reg_wr & (reg_addr == ADDR_CTRL);
  assign wr_mem  = reg_wr & reg_addr[MEM_SEL_BIT];

  // Control register; an MCU reset, unless it is a watchdog wake-up from idle or sleep, returns it to the power-on state.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (mcu_reset_eff)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_q.display_drive_enable <= reg_wdata[CTRL_EN_BIT];
      ctrl_q.wave_type_b          <= reg_wdata[CTRL_WAVE_BIT];
      ctrl_q.cbias_source_select  <=
        lcdb_src_type'(reg_wdata[CTRL_SRC_LSB +: 2]);
      ctrl_q.bias_style_select    <= reg_wdata[CTRL_BIAS_BIT];
    end
  end

  // Display memory: one word per segment, one bit per common line.
  // It has no reset so that a glitch on rst cannot wipe the picture;
  // software must load it after power-up.
  logic [NUM_COM-1:0] mem_q [NUM_SEG];

  always_ff @(posedge clk_sys)
  begin
    if (wr_mem)
    begin
      mem_q[reg_addr[MEM_SEL_BIT-1:0]] <= reg_wdata[NUM_COM-1:0];
    end
  end

  // Sequencer state, declared here so that the status word can show it.
  logic [DIV_W-1:0]  div_q;
  logic              sub_tick;
  logic [SLOT_W-1:0] slot_q;
  logic              half_q;
  logic              frame_pol_q;
  lcdb_mode_type     mode_q;

  // Read data stand for exactly one cycle after the read strobe.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      if (reg_addr == ADDR_CTRL)
      begin
        reg_rdata <= DATA_W'(ctrl_q);
      end
      else if (reg_addr == ADDR_STATUS)
      begin
        reg_rdata <= DATA_W'({mode_q == MODE_FLOAT, drv_reset,
                              frame_pol_q, half_q, slot_q});
      end
      else if (reg_addr[MEM_SEL_BIT])
      begin
        reg_rdata <= DATA_W'(mem_q[reg_addr[MEM_SEL_BIT-1:0]]);
      end
      else
      begin
        // Unmapped addresses read as zero.
        reg_rdata <= '0;
      end
    end
    else
    begin
      reg_rdata <= '0;
    end
  end

  // ****************************************************************
  // Sub-clock divider.
  // ****************************************************************
  assign sub_tick = (div_q == DIV_LAST);

  // Free-running so the frame rate does not depend on bus activity.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      div_q <= '0;
    end
    else if (sub_tick)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + 1'b1;
    end
  end

  // ****************************************************************
  // Frame sequencer.
  // ****************************************************************
  // Style A splits every slot into a positive and a negative half, so
  // each slot is balanced on its own.  Style B spends one tick per
  // slot and flips polarity once per frame, which quarters the drive
  // frequency; the balance then holds over two frames.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      slot_q      <= '0;
      half_q      <= 1'b0;
      frame_pol_q <= 1'b0;
    end
    else if (mode_d != MODE_RUN)
    begin
      // A reset driver restarts at common line 0.
      slot_q      <= '0;
      half_q      <= 1'b0;
      frame_pol_q <= 1'b0;
    end
    else if (sub_tick)
    begin
      if (!ctrl_q.wave_type_b && !half_q)
      begin
        half_q <= 1'b1;
      end
      else
      begin
        half_q <= 1'b0;
        slot_q <= slot_q + 1'b1;
        if (slot_q == SLOT_LAST)
        begin
          frame_pol_q <= ~frame_pol_q;
        end
      end
    end
  end

  // ****************************************************************
  // Level selection.
  // ****************************************************************
  logic                                 pol;
  lcdb_level_type [NUM_COM-1:0]         com_d;
  lcdb_level_type [NUM_SEG-1:0]         seg_d;
  logic [NUM_SEG-1:0]                   seg_on;

  // Style A takes polarity from the half, style B from the frame.
  assign pol = ctrl_q.wave_type_b ? frame_pol_q : half_q;

  // Pixel state for the active common line of every segment.
  always_comb
  begin
    for (int s = 0; s < NUM_SEG; s++)
    begin
      seg_on[s] = mem_q[s][slot_q];
    end
  end

  // 1/3 bias: a selected pixel sees the full VA swing, any other pixel
  // only a third of it, with the sign reversed between polarities so
  // that the average across each pixel is zero.
  always_comb
  begin
    for (int c = 0; c < NUM_COM; c++)
    begin
      if (c == int'(slot_q))
      begin
        com_d[c] = pol ? LVL_VSS : LVL_VA;
      end
      else
      begin
        com_d[c] = pol ? LVL_VB : LVL_VC;
      end
    end
    for (int s = 0; s < NUM_SEG; s++)
    begin
      if (seg_on[s])
      begin
        seg_d[s] = pol ? LVL_VA : LVL_VSS;
      end
      else
      begin
        seg_d[s] = pol ? LVL_VC : LVL_VB;
      end
    end
  end

  // ****************************************************************
  // Pad registers.
  // ****************************************************************
  // Outputs float from power-on until the first clock after rst goes
  // away, matching the floating state of an MCU reset.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_q         <= MODE_FLOAT;
      com_level      <= {NUM_COM{LVL_VSS}};
      segment_output <= {NUM_SEG{LVL_VSS}};
      com_oe         <= '0;
      segment_oe     <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      case (mode_d)
        MODE_FLOAT:
        begin
          com_level      <= {NUM_COM{LVL_VSS}};
          segment_output <= {NUM_SEG{LVL_VSS}};
          com_oe         <= '0;
          segment_oe     <= '0;
        end
        MODE_LOW:
        begin
          com_level      <= {NUM_COM{LVL_VSS}};
          segment_output <= {NUM_SEG{LVL_VSS}};
          com_oe         <= '1;
          segment_oe     <= '1;
        end
        MODE_RUN:
        begin
          com_level      <= com_d;
          segment_output <= seg_d;
          com_oe         <= '1;
          segment_oe     <= '1;
        end
        default:
        begin
          com_level      <= {NUM_COM{LVL_VSS}};
          segment_output <= {NUM_SEG{LVL_VSS}};
          com_oe         <= '0;
          segment_oe     <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Bias supply control.
  // ****************************************************************
  // The pump is only useful when the source sits below the top of the
  // ladder, so the doubler stage stays off for the other sources.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cbias_select <= 1'b0;
      cbias_source <= SRC_SUPPLY_PIN;
      cpump_enable <= 1'b0;
      cpump_boost  <= 1'b0;
    end
    else
    begin
      cbias_select <= ctrl_q.bias_style_select;
      cbias_source <= ctrl_q.cbias_source_select;
      cpump_enable <= ctrl_q.bias_style_select;
      cpump_boost  <= ctrl_q.bias_style_select &&
                      (ctrl_q.cbias_source_select == SRC_SUPPLY_PIN ||
                       ctrl_q.cbias_source_select == SRC_SECOND_PIN);
    end
  end

endmodule : lcdb_driver

// [lcdb_checker_sva.sv]
`timescale 1ns/1ps
module lcdb_checker
  import lcdb_pkg::*;
(
  input wire logic                            clk_sys,
  input wire logic                            rst,
  input wire logic [lcdb_pkg::ADDR_W-1:0]     reg_addr,
  input wire logic [lcdb_pkg::DATA_W-1:0]     reg_wdata,
  input wire logic                            reg_wr,
  input wire logic                            sleep_mode,
  input wire logic                            idle_mode,
  input wire logic                            mcu_reset,
  input wire logic                            wdt_reset,
  input wire lcdb_pkg::lcdb_level_type [lcdb_pkg::NUM_COM-1:0] com_level,
  input wire logic [lcdb_pkg::NUM_COM-1:0]    com_oe,
  input wire lcdb_pkg::lcdb_level_type [lcdb_pkg::NUM_SEG-1:0] segment_output,
  input wire logic [lcdb_pkg::NUM_SEG-1:0]    segment_oe,
  input wire logic                            cbias_select,
  input wire lcdb_pkg::lcdb_src_type          cbias_source,
  input wire logic                            cpump_enable,
  input wire logic                            cpump_boost
);
  logic       en_q, bias_q, eff_c, run_c, low_c;
  logic [1:0] src_q, idx_c;
  logic [2:0] sel_c;

  // A watchdog wake-up from low power must not float the pads.
  assign eff_c = mcu_reset & ~(wdt_reset & (idle_mode | sleep_mode));
  assign run_c = ~eff_c & ~sleep_mode & en_q;
  assign low_c = (&com_oe) & (&segment_oe) & (com_level == '0)
               & (segment_output == '0);

  // Mirror of the control bits, so that pad modes can be predicted.
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      {bias_q, src_q, en_q} <= '0;
    else if (eff_c)
      {bias_q, src_q, en_q} <= '0;
    else if (reg_wr && reg_addr == ADDR_CTRL)
      {bias_q, src_q, en_q} <= {reg_wdata[4:2], reg_wdata[0]};

  // Counts and locates the common line that carries the select level.
  always_comb
  begin
    sel_c = '0;
    idx_c = '0;
    for (int i = 0; i < NUM_COM; i++)
      if (com_level[i] == LVL_VA || com_level[i] == LVL_VSS)
      begin
        sel_c = sel_c + 3'h1;
        idx_c = 2'(i);
      end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_float_mcu: assert property (
    eff_c |=> !(|com_oe) && !(|segment_oe))
    else $error("pads not floating in reset");
  chk_wdt_exempt: assert property (
    mcu_reset && wdt_reset && sleep_mode |=> low_c)
    else $error("watchdog reset floated the pads");
  chk_sleep_low: assert property (!eff_c && sleep_mode |=> low_c)
    else $error("pads not low in sleep");
  // The sampled reset keeps out the attempt at the releasing edge, when
  // the pads still float from the reset itself.
  chk_disabled_low: assert property (
    !rst && !eff_c && !en_q |=> low_c)
    else $error("pads not low while disabled");
  chk_run_one_com: assert property (
    run_c |=> sel_c == 3'h1 && (&com_oe))
    else $error("not one selected common in run");
  chk_slot_start: assert property (
    run_c && !$past(run_c) |=> idx_c == 2'h0)
    else $error("run did not start at slot zero");
  chk_slot_order: assert property (run_c && $past(run_c) |=>
    idx_c == $past(idx_c) || idx_c == $past(idx_c) + 2'h1)
    else $error("common order broken");
  chk_pump_follow: assert property (cpump_enable == $past(bias_q))
    else $error("pump enable wrong");
  chk_pump_boost: assert property (cpump_boost ==
    $past(bias_q && !src_q[0]))
    else $error("pump boost wrong");
  chk_bias_source: assert property (cbias_select == $past(bias_q)
    && cbias_source == $past(src_q))
    else $error("bias selection wrong");

  cover property (run_c ##1 run_c);
  cover property (eff_c);
  cover property (cpump_boost);
endmodule : lcdb_checker

bind lcdb_driver lcdb_checker u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .sleep_mode, .idle_mode, .mcu_reset, .wdt_reset, .com_level,
  .com_oe, .segment_output, .segment_oe, .cbias_select, .cbias_source,
  .cpump_enable, .cpump_boost);

// [lcdb_panel.sv]
`timescale 1ns/1ps
module lcdb_panel
  import lcdb_pkg::*;
(
  input wire logic                            clk_sys,
  input wire logic                            clear,
  input wire lcdb_pkg::lcdb_level_type [lcdb_pkg::NUM_COM-1:0] com_level,
  input wire logic [lcdb_pkg::NUM_COM-1:0]    com_oe,
  input wire lcdb_pkg::lcdb_level_type [lcdb_pkg::NUM_SEG-1:0] segment_output,
  input wire logic [lcdb_pkg::NUM_SEG-1:0]    segment_oe,
  output logic [31:0]                         lit,
  output logic                                dc_zero,
  output logic [15:0]                         com0_moves
);
  int             sum_q [NUM_COM*NUM_SEG];
  lcdb_level_type com0_q;

  // Each pixel integrates its voltage; any residue is a DC bias.
  always_ff @(posedge clk_sys)
  begin
    com0_q <= com_level[0];
    if (clear)
    begin
      lit <= '0;
      com0_moves <= '0;
      foreach (sum_q[i]) sum_q[i] <= 0;
    end
    else if ((&com_oe) && (&segment_oe))
    begin
      if (com_level[0] != com0_q) com0_moves <= com0_moves + 16'h1;
      for (int c = 0; c < NUM_COM; c++)
        for (int s = 0; s < NUM_SEG; s++)
        begin
          sum_q[c*NUM_SEG+s] <= sum_q[c*NUM_SEG+s] + int'(com_level[c])
                                - int'(segment_output[s]);
          if ((int'(com_level[c]) - int'(segment_output[s])) inside {3, -3})
            lit[c*NUM_SEG+s] <= 1'b1;
        end
    end
  end

  // The drive is DC free only when every pixel integral is back at zero.
  always_comb
  begin
    dc_zero = 1'b1;
    foreach (sum_q[i]) if (sum_q[i] != 0) dc_zero = 1'b0;
  end
endmodule : lcdb_panel

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  import lcdb_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, clear = 1'b1, rd_seen = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_mode = 1'b0, idle_mode = 1'b0;
  logic mcu_reset = 1'b0, wdt_reset = 1'b0, flt;
  lcdb_level_type [NUM_COM-1:0] com_level;
  lcdb_level_type [NUM_SEG-1:0] segment_output;
  logic [NUM_COM-1:0] com_oe;
  logic [NUM_SEG-1:0] segment_oe;
  logic cbias_select, cpump_enable, cpump_boost, dc_zero;
  lcdb_src_type cbias_source;
  logic [31:0] lit, exp_lit;
  logic [15:0] com0_moves;
  logic [7:0] exp_q [$];
  logic [3:0] mem [NUM_SEG];
  logic [3:0] cs [5] = '{4'h8, 4'hd, 4'he, 4'hc, 4'h1};
  int errors = 0, compares = 0, cycles = 0, seed = 23856;

  lcdb_driver uut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sleep_mode, .idle_mode, .mcu_reset, .wdt_reset, .com_level,
    .com_oe, .segment_output, .segment_oe, .cbias_select, .cbias_source,
    .cpump_enable, .cpump_boost);
  lcdb_panel u_panel (.clk_sys, .clear, .com_level, .com_oe, .segment_output,
    .segment_oe, .lit, .dc_zero, .com0_moves);

  always #5 clk_sys = ~clk_sys;

  // ****
  // Shared tasks.
  // ****
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : tick
  task automatic final_report();
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // Read data stand only in the cycle after the strobe; judge them there.
  always @(posedge clk_sys) rd_seen <= reg_rd;
  always @(negedge clk_sys)
    if (rd_seen)
      check("read data", reg_rdata, exp_q.pop_front());

  // A hung run is cut short and counted as a failure.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      errors++;
      final_report();
    end
  end

  // ****
  // Main sequence.
  // ****
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_STATUS, 8'h10);
    rd(4'h2, 8'h00);
    tick(1);
    // Oe and levels are judged apart so that no bit is cut off.
    check("idle oe", {com_oe, segment_oe}, 12'hfff);
    check("idle levels", {com_level, segment_output}, 24'h0);
    for (int s = 0; s < NUM_SEG; s++)
    begin
      mem[s] = 4'($random(seed));
      wr(ADDR_MEM_BASE + 4'(s), {4'h0, mem[s]});
      for (int c = 0; c < NUM_COM; c++) exp_lit[c*NUM_SEG+s] = mem[s][c];
    end
    for (int s = 0; s < NUM_SEG; s++)
      rd(ADDR_MEM_BASE + 4'(s), {4'h0, mem[s]});
    // Every bias style and source, with the pump outputs that follow.
    for (int k = 0; k < 8; k++)
    begin
      wr(ADDR_CTRL, {3'h0, 3'(k), 2'h0});
      tick(1);
      check("bias",
            {cbias_select, cbias_source, cpump_enable, cpump_boost},
            {k[2], k[1:0], k[2], k[2] & ~k[0]});
      rd(ADDR_CTRL, {3'h0, 3'(k), 2'h0});
    end
    // One whole drive period in each style; the panel integrates it.
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk_sys);
      clear <= 1'b1;
      wr(ADDR_CTRL, {6'h0, b[0], 1'b1});
      clear <= 1'b0;
      repeat (8 * SUB_DIV - 2) @(posedge clk_sys);
      wr(ADDR_CTRL, 8'h00);
      tick(2);
      check("dc", dc_zero, 1'b1);
      check("lit", lit, exp_lit);
      // The divider runs free, so the opening part slot returns at the
      // close and both the move into and out of the run are counted.
      check("com0 moves", com0_moves, b ? 6 : 10);
    end
    // Reset, watchdog and sleep conditions with the display enabled.
    foreach (cs[i])
    begin
      wr(ADDR_CTRL, 8'h01);
      {mcu_reset, wdt_reset, idle_mode, sleep_mode} <= cs[i];
      flt = cs[i][3] & ~(cs[i][2] & (cs[i][1] | cs[i][0]));
      tick(2);
      check("com_oe", com_oe, flt ? 4'h0 : 4'hf);
      check("segment_oe", segment_oe, flt ? 8'h0 : 8'hff);
      if (!flt && cs[i][0])
        check("sleep", {com_level, segment_output}, 24'h0);
      @(posedge clk_sys);
      {mcu_reset, wdt_reset, idle_mode, sleep_mode} <= 4'h0;
      rd(ADDR_CTRL, flt ? 8'h00 : 8'h01);
    end
    tick(2);
    final_report();
  end
endmodule : testbench
